// file: eses_axil.sv
// AXI4-Lite slave front end giving one-cycle write and read strobes
`timescale 1ns/10ps
module eses_axil
  import eses_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [DATA_W-1:0]      wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic              wr_err,
  output logic                   rd_en,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [DATA_W-1:0] rd_data,
  input  wire logic              rd_err
);

  // ****************************************************************
  // Write channel holding
  // ****************************************************************
  logic              aw_got_q;
  logic              w_got_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0]        rresp_q;

  // Address and data are taken in either order, one write at a time
  assign s_axi_awready = !aw_got_q;
  assign s_axi_wready  = !w_got_q;
  assign wr_en         = aw_got_q && w_got_q && !bvalid_q;
  assign wr_addr       = awaddr_q;
  assign wr_data       = wdata_q;
  assign wr_strb       = wstrb_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_got_q) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_en) begin
        aw_got_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_got_q) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_en) begin
        w_got_q <= 1'b0;
      end
      if (wr_en) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  // Data is sampled at acceptance, so read side effects land once
  assign s_axi_arready = !rvalid_q;
  assign rd_en         = s_axi_arvalid && !rvalid_q;
  assign rd_addr       = s_axi_araddr;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (rd_en) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_data;
      rresp_q  <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// file: eses_pkg.sv
// Package: constants and types shared by the external start and emergency halt block
package eses_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned AXES       = 2;
  localparam int unsigned GPI_MAX    = 6;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned IRQ_W      = 1 + AXES;

  // ****************************************************************
  // Register offsets (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0] OFS_MODE3   = 8'h00;
  localparam logic [7:0] OFS_ERR     = 8'h08;
  localparam logic [7:0] OFS_INST    = 8'h10;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h18;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h1C;
  localparam logic [7:0] AXIS_STRIDE = 8'h04;

  // ****************************************************************
  // Fields
  // ****************************************************************
  localparam int unsigned MODE_LSB      = 0;
  localparam int unsigned MODE_W        = 2;
  localparam int unsigned ERR_EMG_BIT   = 5;
  localparam int unsigned INST_PLUS_BIT = 0;
  localparam int unsigned INST_MINUS_BIT = 1;
  localparam int unsigned INST_GPI_LSB  = 8;
  localparam int unsigned IRQ_EMG_BIT   = 0;
  localparam int unsigned IRQ_START_LSB = 1;

  // External operation encodings of the mode field
  localparam logic [1:0] EXT_OFF   = 2'h0;
  localparam logic [1:0] EXT_FIXED = 2'h1;
  localparam logic [1:0] EXT_CONT  = 2'h2;

  // ****************************************************************
  // Reset values and bus answers
  // ****************************************************************
  localparam logic [1:0]       MODE3_RST   = 2'h0;
  localparam logic [IRQ_W-1:0] IRQ_MSK_RST = 3'h0;
  localparam logic [1:0]       RESP_OKAY   = 2'h0;
  localparam logic [1:0]       RESP_SLVERR = 2'h2;

  // Per-axis drive request towards the pulse engine
  typedef struct packed {
    logic start_plus;
    logic start_minus;
    logic run_plus;
    logic run_minus;
  } eses_drive_type;

endpackage

// file: eses_switch_model.sv
// Switch model: start buttons, emergency button and general input levels
`timescale 1ns/10ps
module eses_switch_model (
  input  wire logic  aclk,
  output logic [3:0]  start_n,
  output logic        halt_n,
  output logic [11:0] gpi
);
  // Button inputs are pulled up, so released buttons read high
  initial begin
    start_n = 4'hF;
    halt_n = 1'h1;
    gpi = 12'h000;
  end
  // Hold one start button low, then release it
  task automatic press(input int idx, input int len);
    @(posedge aclk);
    start_n[idx] <= 1'h0;
    repeat (len) @(posedge aclk);
    start_n[idx] <= 1'h1;
  endtask
  task automatic halt(input int len);
    @(posedge aclk);
    halt_n <= 1'h0;
    repeat ((len < 3) ? 3 : len) @(posedge aclk);
    halt_n <= 1'h1;
  endtask
  // Levels change only just after an edge
  task automatic set_gpi(input logic [11:0] v);
    @(posedge aclk);
    gpi <= v;
  endtask
endmodule

// file: eses_sync.sv
// Two-stage input synchroniser with falling-edge detection
`timescale 1ns/10ps
module eses_sync
  import eses_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] fall
);

  // ****************************************************************
  // Synchroniser stages
  // ****************************************************************
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // Idle level is high, so reset to ones to avoid a false edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edge from the settled stages only
  assign lvl  = sync_q;
  assign fall = prev_q & ~sync_q;

endmodule

// file: eses_top.sv
// External start and emergency halt logic for a two-axis pulse controller
//
// Notes on behaviour
// - Fixed mode: plus start input falling edge launches a plus-direction drive.
// - Fixed mode: minus start input falling edge launches a minus-direction drive.
// - Continuous mode: plus drive runs while plus start input stays low.
// - Continuous mode: minus drive runs while minus start input stays low.
// - Emergency input low stops pulse output on all axes.
// - Emergency stop sets the emergency flag in every axis error status.
// - Emergency input is always active low; no polarity setting exists.
// - General inputs of each axis show in bits 13 to 8 of input status.
// - External start is enabled and selected per axis by mode register three.
`timescale 1ns/10ps
module eses_top
  import eses_pkg::*;
#(
  parameter int unsigned GPI_W = GPI_MAX
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [DATA_W-1:0]     s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [DATA_W-1:0]          s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  first_axis_plus_ext_start,
  input  wire logic                  first_axis_minus_ext_start,
  input  wire logic                  second_axis_plus_ext_start,
  input  wire logic                  second_axis_minus_ext_start,
  input  wire logic                  emergency_halt_input_n,
  input  wire logic [GPI_W-1:0]      first_axis_general_inputs,
  input  wire logic [GPI_W-1:0]      second_axis_general_inputs,
  output eses_drive_type [AXES-1:0]  axis_drive,
  output logic                       pulse_halt,
  output logic                       irq
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (GPI_W < 1 || GPI_W > GPI_MAX) begin : g_bad_gpi
    $error("GPI_W must lie between 1 and 6");
  end

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  localparam int unsigned SYNC_W = 1 + 2 * AXES + 2 * GPI_W;

  logic [SYNC_W-1:0]         sync_lvl;
  logic [SYNC_W-1:0]         sync_fall;
  logic [AXES-1:0]           plus_lvl;
  logic [AXES-1:0]           minus_lvl;
  logic [AXES-1:0]           plus_fall;
  logic [AXES-1:0]           minus_fall;
  logic [AXES-1:0][GPI_W-1:0] gpi_lvl;
  logic                      emg_lvl_n;

  eses_sync #(
    .W (SYNC_W)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     ({emergency_halt_input_n,
                second_axis_general_inputs, first_axis_general_inputs,
                second_axis_minus_ext_start, first_axis_minus_ext_start,
                second_axis_plus_ext_start, first_axis_plus_ext_start}),
    .lvl     (sync_lvl),
    .fall    (sync_fall)
  );

  // Unpack the synchronised vector
  assign plus_lvl   = sync_lvl[1:0];
  assign minus_lvl  = sync_lvl[3:2];
  assign plus_fall  = sync_fall[1:0];
  assign minus_fall = sync_fall[3:2];
  assign gpi_lvl    = sync_lvl[SYNC_W-2:4];
  assign emg_lvl_n  = sync_lvl[SYNC_W-1];

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0]        wr_strb;
  logic              wr_err;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic              rd_err;

  eses_axil u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  logic [AXES-1:0][MODE_W-1:0] mode_q;
  logic [AXES-1:0][MODE_W-1:0] mode_d;
  eses_drive_type [AXES-1:0]   drive_q;
  eses_drive_type [AXES-1:0]   drive_d;
  logic [AXES-1:0]             err_emg_q;
  logic [AXES-1:0]             err_emg_d;
  logic [IRQ_W-1:0]            irq_st_q;
  logic [IRQ_W-1:0]            irq_st_d;
  logic [IRQ_W-1:0]            irq_msk_q;
  logic [IRQ_W-1:0]            irq_msk_d;
  logic                        halt_q;
  logic [IRQ_W-1:0]            irq_evt;

  // Read and write decode, per-axis parts accumulated
  logic [AXES:0][DATA_W-1:0]   rd_acc;
  logic [AXES:0]               rd_hit_acc;
  logic [AXES:0]               wr_hit_acc;
  logic                        rd_irq_st;
  logic                        rd_irq_msk;
  logic                        wr_irq_msk;

  assign rd_irq_st  = rd_addr[7:2] == OFS_IRQ_ST[7:2];
  assign rd_irq_msk = rd_addr[7:2] == OFS_IRQ_MSK[7:2];
  assign wr_irq_msk = wr_addr[7:2] == OFS_IRQ_MSK[7:2];
  assign rd_acc[0]     = ({DATA_W{rd_irq_st}} & DATA_W'(irq_st_q))
                       | ({DATA_W{rd_irq_msk}} & DATA_W'(irq_msk_q));
  assign rd_hit_acc[0] = rd_irq_st || rd_irq_msk;
  assign wr_hit_acc[0] = wr_irq_msk;
  assign rd_data = rd_acc[AXES];
  assign rd_err  = !rd_hit_acc[AXES];
  assign wr_err  = !wr_hit_acc[AXES];

  // ****************************************************************
  // Per-axis logic
  // ****************************************************************
  for (genvar i = 0; i < AXES; i++) begin : g_axis
    localparam logic [7:0] A_MODE = OFS_MODE3 + 8'(i * AXIS_STRIDE);
    localparam logic [7:0] A_ERR  = OFS_ERR + 8'(i * AXIS_STRIDE);
    localparam logic [7:0] A_INST = OFS_INST + 8'(i * AXIS_STRIDE);

    logic              rd_mode;
    logic              rd_err_reg;
    logic              rd_inst;
    logic              wr_mode;
    logic              is_fixed;
    logic              is_cont;
    logic [DATA_W-1:0] inst_word;

    assign rd_mode    = rd_addr[7:2] == A_MODE[7:2];
    assign rd_err_reg = rd_addr[7:2] == A_ERR[7:2];
    assign rd_inst    = rd_addr[7:2] == A_INST[7:2];
    assign wr_mode    = wr_addr[7:2] == A_MODE[7:2];

    // General inputs in bits 13 to 8
    assign inst_word = (DATA_W'(gpi_lvl[i]) << INST_GPI_LSB)
                     | (DATA_W'(plus_lvl[i]) << INST_PLUS_BIT)
                     | (DATA_W'(minus_lvl[i]) << INST_MINUS_BIT);

    assign rd_acc[i+1] = rd_acc[i]
                       | ({DATA_W{rd_mode}} & (DATA_W'(mode_q[i]) << MODE_LSB))
                       | ({DATA_W{rd_err_reg}} & (DATA_W'(err_emg_q[i]) << ERR_EMG_BIT))
                       | ({DATA_W{rd_inst}} & inst_word);
    assign rd_hit_acc[i+1] = rd_hit_acc[i] || rd_mode || rd_err_reg || rd_inst;
    assign wr_hit_acc[i+1] = wr_hit_acc[i] || wr_mode;

    // Mode register three selects external operation
    assign mode_d[i] = (wr_en && wr_mode && wr_strb[0])
                     ? wr_data[MODE_LSB +: MODE_W] : mode_q[i];
    assign is_fixed  = mode_q[i] == EXT_FIXED;
    assign is_cont   = mode_q[i] == EXT_CONT;

    // Edge start; level run; gated by halt
    assign drive_d[i] = '{start_plus:  is_fixed && plus_fall[i] && emg_lvl_n,
                          start_minus: is_fixed && minus_fall[i] && emg_lvl_n,
                          run_plus:    is_cont && !plus_lvl[i] && emg_lvl_n,
                          run_minus:   is_cont && !minus_lvl[i] && emg_lvl_n};

    // Flag set wins over the read clear
    assign err_emg_d[i] = !emg_lvl_n || (err_emg_q[i] && !(rd_en && rd_err_reg));

    // Start event for the interrupt: any new drive request
    assign irq_evt[IRQ_START_LSB + i] = drive_d[i].start_plus || drive_d[i].start_minus
                                      || (drive_d[i].run_plus && !drive_q[i].run_plus)
                                      || (drive_d[i].run_minus && !drive_q[i].run_minus);

    // Fixed plus start fires on its edge for exactly one cycle
    property p_fixed_plus;
      @(posedge aclk) disable iff (!aresetn)
      (is_fixed && plus_fall[i] && emg_lvl_n) |=> drive_q[i].start_plus ##1 !drive_q[i].start_plus;
    endproperty
    a_fixed_plus: assert property (p_fixed_plus) else $error("fixed plus start missed");

    property p_fixed_minus;
      @(posedge aclk) disable iff (!aresetn)
      drive_q[i].start_minus |-> $past(is_fixed) && $past(minus_lvl[i], 2) && !$past(minus_lvl[i]);
    endproperty
    a_fixed_minus: assert property (p_fixed_minus) else $error("minus start without edge");

    property p_cont_plus;
      @(posedge aclk) disable iff (!aresetn)
      (is_cont && emg_lvl_n && !plus_lvl[i]) [*3] |=> drive_q[i].run_plus;
    endproperty
    a_cont_plus: assert property (p_cont_plus) else $error("plus run not held");

    property p_cont_minus;
      @(posedge aclk) disable iff (!aresetn)
      $rose(minus_lvl[i]) |=> !drive_q[i].run_minus;
    endproperty
    a_cont_minus: assert property (p_cont_minus) else $error("minus run after release");

    property p_emg_flag;
      @(posedge aclk) disable iff (!aresetn)
      $fell(emg_lvl_n) |=> err_emg_q[i] && halt_q;
    endproperty
    a_emg_flag: assert property (p_emg_flag) else $error("emergency flag not set");

    property p_mode_off;
      @(posedge aclk) disable iff (!aresetn)
      (mode_q[i] == EXT_OFF) |=> (drive_q[i] == '0);
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("drive while external mode off");

    property p_gpi_status;
      @(posedge aclk) disable iff (!aresetn)
      aresetn |->
      ##2 inst_word[INST_GPI_LSB +: GPI_W] == $past(i == 0 ? first_axis_general_inputs
                                                           : second_axis_general_inputs, 2);
    endproperty
    a_gpi_status: assert property (p_gpi_status) else $error("general inputs misreported");
  end

  // ****************************************************************
  // Interrupt and halt
  // ****************************************************************
  // Emergency onset is the shared interrupt event
  assign irq_evt[IRQ_EMG_BIT] = sync_fall[SYNC_W-1];
  assign irq_st_d  = irq_evt | (irq_st_q & ~{IRQ_W{rd_en && rd_irq_st}});
  assign irq_msk_d = (wr_en && wr_irq_msk && wr_strb[0]) ? wr_data[IRQ_W-1:0] : irq_msk_q;

  // Level output so a missed edge cannot lose it
  assign irq        = |(irq_st_q & irq_msk_q);
  assign axis_drive = drive_q;
  assign pulse_halt = halt_q;

  // Fixed active-low halt, no polarity option
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q    <= {AXES{MODE3_RST}};
      drive_q   <= '0;
      err_emg_q <= '0;
      irq_st_q  <= '0;
      irq_msk_q <= IRQ_MSK_RST;
      halt_q    <= 1'b0;
    end else begin
      mode_q    <= mode_d;
      drive_q   <= drive_d;
      err_emg_q <= err_emg_d;
      irq_st_q  <= irq_st_d;
      irq_msk_q <= irq_msk_d;
      halt_q    <= !emg_lvl_n;
    end
  end

  // ****************************************************************
  // Checks on the shared halt path and the plus edge detect
  // ****************************************************************
  property p_halt_all;
    @(posedge aclk) disable iff (!aresetn)
    halt_q |-> (drive_q == '0);
  endproperty
  a_halt_all: assert property (p_halt_all) else $error("drive active during halt");

  property p_halt_pin;
    @(posedge aclk) disable iff (!aresetn)
    (!emergency_halt_input_n) [*3] |-> ##[1:2] halt_q;
  endproperty
  a_halt_pin: assert property (p_halt_pin) else $error("low emergency pin did not halt");

  property p_edge_compare;
    @(posedge aclk) disable iff (!aresetn)
    plus_fall[0] |-> $past(plus_lvl[0]) && !plus_lvl[0];
  endproperty
  a_edge_compare: assert property (p_edge_compare) else $error("edge not from compare");

endmodule

// file: external_start_and_emergency_stop_tb_top.sv
// Testbench: bus tasks, switch model and one task per scenario
`timescale 1ns/10ps
module external_start_and_emergency_stop_tb_top;
  import eses_pkg::*;
  logic                      aclk = 1'h0;
  logic                      aresetn = 1'h0;
  logic [7:0]                awaddr = 8'h00;
  logic [7:0]                araddr = 8'h00;
  logic [31:0]               wdata = 32'h0;
  logic                      awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic                      arvalid = 1'h0, rready = 1'h0;
  logic                      awready, wready, bvalid, arready, rvalid, pulse_halt, irq, halt_n;
  logic [1:0]                bresp, rresp;
  logic [31:0]               rdata, d;
  logic [3:0]                start_n;
  logic [11:0]               gpi;
  logic [7:0]                drv;
  eses_drive_type [AXES-1:0] axis_drive;
  int                        hits [9];
  int                        overlap = 0;
  int                        bad_count = 0;
  int                        comparisons = 0;

  always #50 aclk = ~aclk;
  assign drv = axis_drive;

  eses_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .first_axis_plus_ext_start(start_n[0]), .first_axis_minus_ext_start(start_n[1]),
    .second_axis_plus_ext_start(start_n[2]), .second_axis_minus_ext_start(start_n[3]),
    .emergency_halt_input_n(halt_n), .first_axis_general_inputs(gpi[5:0]),
    .second_axis_general_inputs(gpi[11:6]), .axis_drive(axis_drive),
    .pulse_halt(pulse_halt), .irq(irq));
  eses_switch_model sw (.aclk(aclk), .start_n(start_n), .halt_n(halt_n), .gpi(gpi));

  // ****************
  // Monitor and helpers
  // ****************
  // Falling edge sees settled drive bits; a halt beside a running drive or an unknown counts
  always @(negedge aclk) begin
    for (int i = 0; i < 8; i++) hits[i] += drv[i];
    hits[8] += pulse_halt;
    if ((pulse_halt && (drv & 8'h33) != 8'h00) || $isunknown({drv, pulse_halt})) overlap++;
  end
  task automatic clr();
    foreach (hits[i]) hits[i] = 0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    bready <= 1'h1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'h0;
    chk(bresp, (a < 8'h20) ? RESP_OKAY : RESP_SLVERR);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'h0;
    v = rdata;
    chk(rresp, (a < 8'h20) ? RESP_OKAY : RESP_SLVERR);
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_regs();
    chk(pulse_halt, 0);
    rd(OFS_MODE3, d);
    chk(d, 0);
    wr(OFS_MODE3 + AXIS_STRIDE, 32'h2);
    rd(OFS_MODE3 + AXIS_STRIDE, d);
    chk(d, 32'h2);
    wr(8'h40, 32'h1);
    rd(8'h40, d);
    chk(d, 0);
  endtask
  task automatic t_fixed();
    wr(OFS_MODE3, {30'h0, EXT_FIXED});
    wr(OFS_MODE3 + AXIS_STRIDE, {30'h0, EXT_FIXED});
    for (int p = 0; p < 4; p++) begin
      clr();
      sw.press(p, 4);
      repeat (8) @(posedge aclk);
      chk(hits[(p / 2) * 4 + 3 - p % 2], 1);
      chk(hits[0] + hits[1] + hits[2] + hits[3] + hits[4] + hits[5] + hits[6] + hits[7], 1);
      chk(hits[8], 0);
    end
    wr(OFS_MODE3, {30'h0, EXT_OFF});
    clr();
    sw.press(0, 4);
    repeat (8) @(posedge aclk);
    chk(hits[3] + hits[1], 0);
  endtask
  task automatic t_cont();
    wr(OFS_MODE3, {30'h0, EXT_CONT});
    wr(OFS_MODE3 + AXIS_STRIDE, {30'h0, EXT_CONT});
    for (int p = 0; p < 4; p++) begin
      clr();
      sw.press(p, 5 + p);
      repeat (8) @(posedge aclk);
      chk(hits[(p / 2) * 4 + 1 - p % 2], 5 + p);
    end
  endtask
  task automatic t_emerg();
    clr();
    fork
      sw.press(0, 20);
      begin
        repeat (6) @(posedge aclk);
        sw.halt(5);
      end
    join
    repeat (8) @(posedge aclk);
    chk(hits[8], 5);
    chk(overlap, 0);
    rd(OFS_ERR, d);
    chk(d, 32'h1 << ERR_EMG_BIT);
    rd(OFS_ERR + AXIS_STRIDE, d);
    chk(d, 32'h1 << ERR_EMG_BIT);
    rd(OFS_ERR, d);
    chk(d, 0);
  endtask
  task automatic t_gpi();
    sw.set_gpi(12'hA95);
    repeat (4) @(posedge aclk);
    rd(OFS_INST, d);
    chk(d & 32'h3F00, 32'h1500);
    rd(OFS_INST + AXIS_STRIDE, d);
    chk(d & 32'h3F00, 32'h2A00);
  endtask
  task automatic t_irq();
    rd(OFS_IRQ_ST, d);
    chk(d, 32'h7);
    wr(OFS_IRQ_MSK, 32'h2);
    wr(OFS_MODE3, {30'h0, EXT_FIXED});
    sw.press(0, 4);
    repeat (6) @(posedge aclk);
    chk(irq, 1);
    rd(OFS_IRQ_ST, d);
    chk(d, 32'h2);
    repeat (2) @(posedge aclk);
    chk(irq, 0);
    // Masked event still latches status but keeps the line low
    wr(OFS_IRQ_MSK, 32'h0);
    sw.press(0, 4);
    repeat (6) @(posedge aclk);
    chk(irq, 0);
    rd(OFS_IRQ_ST, d);
    chk(d, 32'h2);
  endtask

  // Reset for three cycles, then the scenarios in turn
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_fixed();
    t_cont();
    t_emerg();
    t_gpi();
    t_irq();
    give_verdict();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge aclk);
    bad_count++;
    give_verdict();
  end
endmodule
